// File: rtl/lin_resp_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "lin_resp_map.svh"
// How it works
// R1: Rx response start clears tx length, counts received bytes, rx length kept; code clamps rx length to 8.
// R2: Rx error stops reception, flags it, tx length keeps good byte count.
// R3: Good Rx response sets rx complete after checksum, lengths then equal.
// R4: Tx response start clears rx length, counts sent bytes, tx length kept; code clamps tx length to 8.
// R5: Tx error stops sending, flags it, rx length keeps good byte count.
// R6: Good Tx response sets tx complete after checksum, lengths then equal.
// R7: Reset and UART mode hold lengths at zero; UART ignores length writes.
// R8: Header end sets header done; legacy lengths decoded in the same cycle; never in UART.
// R9: UART sets rx complete per received and tx complete per sent character.
// R10: Summary flag is OR of error bits; writing one clears all.
// R11: Monitored bit differing from driven bit flags bit error, in LIN and UART; aborts in LIN only.
// R12: Checksum error when carry sum of bytes plus checksum is not FF.
// R13: Parity mismatch in identifier flagged, nothing corrected.
// R14: Dominant stop bit flags framing error in LIN and UART.
// R15: Frame not finished in maximum time flags timeout, unless disabled.
// R16: Overrun on non-abort command while busy, or UART unread byte overwritten.
// R17: Any LIN error except overrun returns to withdrawal code 000; abort while busy flags.
// R18: Break during response aborts, bit error on Tx, framing on Rx.
// R19: Checksum inverted carry sum, identifier included unless legacy, latched at start.
// R20: Identifier status 1xx for identifiers 3C to 3F, else 000.
// R21: Eight-byte buffer at 3-bit index, post-increment wraps unless disabled.
// R22: Four status flags feed two interrupts, each gated by its enable.
// R23: Error interrupt from summary flag, event interrupt from other flags.
module lin_resp_ctrl import lin_resp_pkg::*; #(
	parameter int FRAME_CYC = `FRAME_MAX_NS / `CLK_PERIOD_NS
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic lin_enable,
	input wire logic legacy_protocol_select,
	input wire logic [1:0] conf_sel,
	input wire logic cmd_wr,
	input wire logic [2:0] cmd_wdata,
	input wire logic dl_wr,
	input wire logic [7:0] dl_wdata,
	input wire logic [3:0] flag_clr,
	input wire logic [3:0] interrupt_enable_register,
	input wire logic sel_wr,
	input wire logic [3:0] sel_wdata,
	input wire logic dat_wr,
	input wire logic [7:0] dat_wdata,
	input wire logic dat_rd,
	input wire logic hdr_done,
	input wire logic [7:0] hdr_pid,
	input wire logic rx_stb,
	input wire logic [7:0] rx_data,
	input wire logic tx_ready,
	input wire logic tx_sent,
	input wire logic bit_sample,
	input wire logic tx_bit,
	input wire logic bus_rx,
	input wire logic stop_dominant,
	input wire logic sync_fault,
	input wire logic break_seen,
	output logic [2:0] command_field,
	output logic busy,
	output logic [3:0] rx_length_field,
	output logic [3:0] tx_length_field,
	output logic rx_complete_flag,
	output logic tx_complete_flag,
	output logic header_done_flag,
	output logic error_summary_flag,
	output err_t error_register,
	output logic [2:0] ident_status_field,
	output logic [2:0] buffer_index,
	output logic increment_disable,
	output logic [7:0] data_port,
	output logic tx_valid,
	output logic [7:0] tx_data,
	output logic irq_error,
	output logic irq_event
);
	// ---------------------------------------------
	// State
	// ---------------------------------------------
	resp_st_t st_r, st_nxt;
	logic [2:0] cmd_r, cmd_nxt;
	logic [3:0] rxdl_r, rxdl_nxt, txdl_r, txdl_nxt, feed_r;
	logic [7:0] buf_r [8];
	logic [7:0] sum_r, pid_r, urx_r;
	logic feed_done_r, unread_r, upend_r, busy_r;
	logic bus_s1_r, bus_s2_r;
	logic [31:0] frame_cnt_r;
	logic frame_on_r;
	err_t err_r, err_set, err_nxt;
	logic rxok_nxt, txok_nxt, idok_nxt;

	function automatic logic [7:0] csum_add(input logic [7:0] a, input logic [7:0] b);
		logic [8:0] s;
		s = {1'b0, a} + {1'b0, b};
		csum_add = s[7:0] + {7'h0, s[8]};
	endfunction : csum_add

	function automatic logic [3:0] clamp(input logic [3:0] n);
		clamp = (n > `LEN_MAX) ? `LEN_MAX : n;
	endfunction : clamp

	// ---------------------------------------------
	// Decode
	// ---------------------------------------------
	wire uart_mode = cmd_r[`CMD_UART_BIT];
	wire busy_w = (st_r != ST_IDLE) | upend_r;
	wire cmd_take = cmd_wr & ~busy_w & lin_enable;
	wire cmd_abort = cmd_wr & busy_w & ~uart_mode & (cmd_wdata[1:0] == 2'h0);
	wire cmd_ovr = cmd_wr & busy_w & ~uart_mode & (cmd_wdata[1:0] != 2'h0);
	wire start_rx = cmd_take & (cmd_wdata == `CMD_RXRESP);
	wire start_tx = cmd_take & (cmd_wdata == `CMD_TXRESP);
	wire start_hdr = cmd_take & (cmd_wdata == `CMD_TXHDR);
	wire lin_hdr = hdr_done & ~uart_mode;
	wire tx_act = (st_r == ST_TXRESP) | (st_r == ST_TXHDR) | upend_r;
	wire bit_miss = tx_act & bit_sample & (bus_s2_r != tx_bit);
	wire [7:0] rx_sum = csum_add(sum_r, rx_data);
	wire rx_crc = txdl_r == rxdl_r;
	wire rx_hit = (st_r == ST_RXRESP) & rx_stb & ~stop_dominant & ~break_seen;
	wire rx_done = rx_hit & rx_crc & (rx_sum == `CSUM_GOOD);
	wire tx_crc = rxdl_r == txdl_r;
	wire tx_hit = (st_r == ST_TXRESP) & tx_sent;
	wire tx_done = tx_hit & tx_crc;
	wire par_bad = (hdr_pid[6] != ^{hdr_pid[0], hdr_pid[1], hdr_pid[2], hdr_pid[4]})
		| (hdr_pid[7] != ~^{hdr_pid[1], hdr_pid[3], hdr_pid[4], hdr_pid[5]});
	wire to_en = (conf_sel != `CONF_NOTO) & (conf_sel != `CONF_NOCRC);
	wire to_hit = frame_on_r & to_en & (frame_cnt_r == 32'(FRAME_CYC - 1));
	wire urx_ev = uart_mode & cmd_r[`CMD_URX_BIT] & rx_stb;
	wire utx_ev = uart_mode & upend_r & tx_sent;
	wire [7:0] feed_d = (feed_r == txdl_r) ? ~sum_r : buf_r[feed_r[2:0]];
	wire feed_v = (st_r == ST_TXRESP) & ~feed_done_r;
	wire fifo_ready;
	wire uart_push = dat_wr & uart_mode & cmd_r[0] & ~upend_r & fifo_ready;
	wire feed_push = feed_v & fifo_ready;
	wire lin_acc = (dat_rd | (dat_wr & ~busy_w)) & ~uart_mode;
	wire idx_step = lin_acc & ~increment_disable;
	wire [2:0] idx_nxt = sel_wr ? sel_wdata[2:0] : (buffer_index + {2'h0, idx_step});
	wire uart_rdclr = dat_rd & uart_mode;
	wire [7:0] sum_init = legacy_protocol_select ? 8'h00 : pid_r;
	wire [3:0] len13 = (hdr_pid[5:4] == 2'h3) ? `LEN_MAX :
		(hdr_pid[5:4] == 2'h2) ? `LEN13_MID : `LEN13_SHORT;
	wire buf_flush;

	// ---------------------------------------------
	// Error events
	// ---------------------------------------------
	always_comb begin
		err_set = '0;
		// R11: bit check
		// R18: break in Tx
		err_set.biterr = bit_miss | ((st_r == ST_TXRESP) & break_seen);
		// R12: checksum check
		err_set.checksum = rx_hit & rx_crc & (rx_sum != `CSUM_GOOD);
		// R13: parity check
		err_set.parity = lin_hdr & par_bad;
		err_set.sync = sync_fault & ~uart_mode;
		// R14: dominant stop
		// R18: break in Rx
		err_set.framing = stop_dominant | ((st_r == ST_RXRESP) & break_seen);
		// R15: frame timeout
		err_set.timeout = to_hit;
		// R16: overrun sources
		err_set.overrun = cmd_ovr | (urx_ev & unread_r);
		// R17: abort flag
		err_set.abort = cmd_abort;
	end
	wire stop_any = ~uart_mode & |(err_set & ~err_t'(8'h20));

	// ---------------------------------------------
	// Command and lengths
	// ---------------------------------------------
	always_comb begin
		st_nxt = st_r;
		cmd_nxt = cmd_r;
		rxdl_nxt = rxdl_r;
		txdl_nxt = txdl_r;
		if (dl_wr && !busy_w && !uart_mode) begin
			rxdl_nxt = dl_wdata[`DL_RX_MSB:`DL_RX_LSB];
			txdl_nxt = dl_wdata[`DL_TX_MSB:`DL_TX_LSB];
		end
		// R8: legacy length decode
		if (lin_hdr && legacy_protocol_select) begin
			rxdl_nxt = len13;
			txdl_nxt = len13;
		end
		// R1: count received bytes
		if (rx_hit && !rx_crc) begin
			txdl_nxt = txdl_r + 4'h1;
		end
		// R4: count sent bytes
		if (tx_hit && !tx_crc) begin
			rxdl_nxt = rxdl_r + 4'h1;
		end
		if (rx_done || tx_done || (st_r == ST_TXHDR && hdr_done)) begin
			st_nxt = ST_IDLE;
		end
		// R2: error stops Rx
		// R5: error stops Tx
		// R17: withdrawal
		if (!lin_enable || stop_any || cmd_abort) begin
			st_nxt = ST_IDLE;
			cmd_nxt = `CMD_ABORT;
		end else if (cmd_take) begin
			cmd_nxt = cmd_wdata;
			st_nxt = start_rx ? ST_RXRESP : start_tx ? ST_TXRESP : start_hdr ? ST_TXHDR : ST_IDLE;
			// R1: clear tx length
			if (start_rx) begin
				txdl_nxt = `LEN_RESET;
				rxdl_nxt = clamp(rxdl_r);
			end
			// R4: clear rx length
			if (start_tx) begin
				rxdl_nxt = `LEN_RESET;
				txdl_nxt = clamp(txdl_r);
			end
		end
		// R7: UART zero lengths
		if (cmd_nxt[`CMD_UART_BIT]) begin
			rxdl_nxt = `LEN_RESET;
			txdl_nxt = `LEN_RESET;
		end
	end

	// ---------------------------------------------
	// Flags
	// ---------------------------------------------
	// R3: Rx complete
	// R9: UART character flags
	assign rxok_nxt = (rx_complete_flag & ~flag_clr[0]) | rx_done | urx_ev;
	// R6: Tx complete
	assign txok_nxt = (tx_complete_flag & ~flag_clr[1] & ~(dat_wr & uart_mode)) | tx_done | utx_ev;
	// R8: header done
	assign idok_nxt = (header_done_flag & ~flag_clr[2]) | lin_hdr;
	// R10: clear all errors
	assign err_nxt = (error_register & ~{8{flag_clr[3] | uart_rdclr}}) | err_set;

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			st_r <= ST_IDLE;
			cmd_r <= `CMD_ABORT;
			rxdl_r <= `LEN_RESET;
			txdl_r <= `LEN_RESET;
			busy_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			cmd_r <= cmd_nxt;
			rxdl_r <= rxdl_nxt;
			txdl_r <= txdl_nxt;
			busy_r <= (st_nxt != ST_IDLE) | ((upend_r | uart_push) & ~tx_sent);
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			rx_complete_flag <= 1'b0;
			tx_complete_flag <= 1'b0;
			header_done_flag <= 1'b0;
			error_register <= '0;
			error_summary_flag <= 1'b0;
			irq_error <= 1'b0;
			irq_event <= 1'b0;
		end else begin
			rx_complete_flag <= rxok_nxt;
			tx_complete_flag <= txok_nxt;
			header_done_flag <= idok_nxt;
			error_register <= err_nxt;
			// R10: summary is OR
			error_summary_flag <= |err_nxt;
			// R22: gated interrupts
			// R23: two request lines
			irq_error <= (|err_nxt) & interrupt_enable_register[3];
			irq_event <= |({idok_nxt, txok_nxt, rxok_nxt} & interrupt_enable_register[2:0]);
		end
	end

	// ---------------------------------------------
	// Header, checksum and frame timer
	// ---------------------------------------------
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			bus_s1_r <= 1'b1;
			bus_s2_r <= 1'b1;
			pid_r <= 8'h00;
			ident_status_field <= 3'h0;
			sum_r <= 8'h00;
			feed_r <= 4'h0;
			feed_done_r <= 1'b0;
			frame_on_r <= 1'b0;
			frame_cnt_r <= 32'h0;
		end else begin
			bus_s1_r <= bus_rx;
			bus_s2_r <= bus_s1_r;
			if (lin_hdr) begin
				pid_r <= hdr_pid;
				// R20: special identifiers
				ident_status_field <= (hdr_pid[5:0] >= `ID_SPECIAL) ? {1'b1, hdr_pid[1:0]} : 3'h0;
			end
			// R19: latch protocol and seed sum
			if (start_rx || start_tx) begin
				sum_r <= sum_init;
				feed_r <= 4'h0;
				feed_done_r <= 1'b0;
			end else if (rx_hit) begin
				sum_r <= rx_sum;
			end else if (feed_push) begin
				// R19: carry-wrapped sum
				if (feed_r == txdl_r) begin
					feed_done_r <= 1'b1;
				end else begin
					sum_r <= csum_add(sum_r, feed_d);
					feed_r <= feed_r + 4'h1;
				end
			end
			// R15: frame timer
			if (lin_hdr) begin
				frame_on_r <= 1'b1;
				frame_cnt_r <= 32'h0;
			end else if (rx_done || tx_done || stop_any || cmd_abort || to_hit) begin
				frame_on_r <= 1'b0;
			end else if (frame_on_r) begin
				frame_cnt_r <= frame_cnt_r + 32'h1;
			end
		end
	end

	// ---------------------------------------------
	// Data buffer and UART data
	// ---------------------------------------------
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			buffer_index <= 3'h0;
			increment_disable <= 1'b0;
			data_port <= 8'h00;
			urx_r <= 8'h00;
			unread_r <= 1'b0;
			upend_r <= 1'b0;
		end else begin
			// R21: indexed access
			buffer_index <= idx_nxt;
			if (sel_wr) begin
				increment_disable <= sel_wdata[`SEL_INCDIS_BIT];
			end
			data_port <= uart_mode ? (urx_ev ? rx_data : urx_r) : buf_r[idx_nxt];
			if (urx_ev) begin
				urx_r <= rx_data;
			end
			// R16: unread byte tracking
			unread_r <= urx_ev | (unread_r & ~uart_rdclr);
			upend_r <= (upend_r | uart_push) & ~tx_sent & cmd_nxt[`CMD_UART_BIT];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rx_hit && !rx_crc) begin
			buf_r[txdl_r[2:0]] <= rx_data;
		end else if (dat_wr && lin_acc) begin
			buf_r[buffer_index] <= dat_wdata;
		end
	end

	// ---------------------------------------------
	// Outgoing byte buffer
	// ---------------------------------------------
	assign buf_flush = stop_any | cmd_abort | ~lin_enable;
	pair_buffer #(.W(8), .DEPTH(2)) u_txbuf (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.flush(buf_flush),
		.in_valid(feed_v | uart_push),
		.in_ready(fifo_ready),
		.in_data(uart_push ? dat_wdata : feed_d),
		.out_valid(tx_valid),
		.out_ready(tx_ready),
		.out_data(tx_data)
	);
	assign command_field = cmd_r;
	assign busy = busy_r;
	assign rx_length_field = rxdl_r;
	assign tx_length_field = txdl_r;

	// ---------------------------------------------
	// Checks
	// ---------------------------------------------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!arst_n);
	sequence s_rx_cmd;
		start_rx;
	endsequence
	sequence s_tx_cmd;
		start_tx;
	endsequence
	sequence s_bit_miss;
		bit_miss && !uart_mode && lin_enable;
	endsequence

	a_rx_len_clear: assert property (s_rx_cmd |=> tx_length_field == 4'h0 && busy) // R1
		else $error("Rx start left tx length set");
	a_tx_len_clear: assert property (s_tx_cmd |=> rx_length_field == 4'h0 && busy) // R4
		else $error("Tx start left rx length set");
	a_rx_done_equal: assert property ($rose(rx_complete_flag) && !uart_mode |-> rx_length_field == tx_length_field) // R3
		else $error("Rx complete with unequal lengths");
	a_tx_done_equal: assert property ($rose(tx_complete_flag) && !uart_mode |-> rx_length_field == tx_length_field) // R6
		else $error("Tx complete with unequal lengths");
	a_uart_len_zero: assert property (uart_mode |-> rx_length_field == 4'h0 && tx_length_field == 4'h0) // R7
		else $error("Lengths nonzero in UART mode");
	a_summary_or: assert property (error_summary_flag == |error_register) // R10
		else $error("Summary flag differs from error OR");
	a_bit_abort: assert property (s_bit_miss |=> error_register.biterr && command_field == 3'h0 ##1 !busy) // R11
		else $error("Bit mismatch did not abort");
	a_ovr_busy: assert property (cmd_ovr |=> error_register.overrun && command_field == $past(cmd_r)) // R16
		else $error("Busy command did not flag overrun");
	a_abort_flag: assert property (cmd_abort |=> error_register.abort && command_field == 3'h0) // R17
		else $error("Abort while busy not flagged");
	a_ident_stat: assert property (lin_hdr && hdr_pid[5:0] >= 6'h3C |=> ident_status_field == {1'b1, $past(hdr_pid[1:0])}) // R20
		else $error("Identifier status wrong");
	a_index_wrap: assert property (idx_step && !sel_wr && buffer_index == 3'h7 |=> buffer_index == 3'h0) // R21
		else $error("Buffer index did not wrap");
	a_irq_err: assert property (irq_error == (error_summary_flag && $past(interrupt_enable_register[3]))) // R23
		else $error("Error interrupt not tied to summary");
endmodule : lin_resp_ctrl
`default_nettype wire

// File: rtl/lin_resp_map.svh
`ifndef LIN_RESP_MAP_SVH
`define LIN_RESP_MAP_SVH
// ---------------------------------------------
// Command codes and field positions
// ---------------------------------------------
`define CMD_ABORT 3'h0
`define CMD_TXHDR 3'h1
`define CMD_RXRESP 3'h2
`define CMD_TXRESP 3'h3
`define CMD_UART_BIT 2
`define CMD_URX_BIT 1
`define DL_TX_MSB 7
`define DL_TX_LSB 4
`define DL_RX_MSB 3
`define DL_RX_LSB 0
`define SEL_INCDIS_BIT 3
// ---------------------------------------------
// Reset values and limits
// ---------------------------------------------
`define LEN_RESET 4'h0
`define LEN_MAX 4'h8
`define LEN13_SHORT 4'h2
`define LEN13_MID 4'h4
`define CONF_NOCRC 2'h1
`define CONF_NOTO 2'h2
`define CSUM_GOOD 8'hFF
`define ID_SPECIAL 6'h3C
// ---------------------------------------------
// Timing
// ---------------------------------------------
`define FRAME_MAX_NS 10000000
`define CLK_PERIOD_NS 20
`endif

// File: rtl/lin_resp_pkg.sv
package lin_resp_pkg;
	typedef enum logic [1:0] {ST_IDLE, ST_TXHDR, ST_RXRESP, ST_TXRESP} resp_st_t;
	typedef struct packed {
		logic abort;
		logic timeout;
		logic overrun;
		logic framing;
		logic sync;
		logic parity;
		logic checksum;
		logic biterr;
	} err_t;
endpackage : lin_resp_pkg

// File: rtl/pair_buffer.sv
`timescale 1ns/1ps
`default_nettype none
module pair_buffer #(
	parameter int W = 8,
	parameter int DEPTH = 2
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic flush,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	// ---------------------------------------------
	// Shift slots, head at slot 0
	// ---------------------------------------------
	logic [W-1:0] mem_r [DEPTH];
	logic [DEPTH-1:0] v_r;
	logic [DEPTH-1:0] v_sh;
	wire pop = v_r[0] & out_ready;
	wire push = in_valid & in_ready;
	assign in_ready = ~v_r[DEPTH-1];
	assign out_valid = v_r[0];
	assign out_data = mem_r[0];
	genvar i;
	for (i = 0; i < DEPTH; i++) begin : g_slot
		logic load;
		logic v_up;
		if (i == DEPTH-1) begin : g_last
			assign v_up = 1'b0;
		end else begin : g_inner
			assign v_up = v_r[i+1];
		end
		assign v_sh[i] = pop ? v_up : v_r[i];
		if (i == 0) begin : g_first
			assign load = push & ~v_sh[0];
		end else begin : g_rest
			assign load = push & ~v_sh[i] & v_sh[i-1];
		end
		always_ff @(posedge clk_sys or negedge arst_n) begin
			if (!arst_n) begin
				v_r[i] <= 1'b0;
			end else begin
				v_r[i] <= ~flush & (v_sh[i] | load);
			end
		end
		always_ff @(posedge clk_sys) begin
			if (load) begin
				mem_r[i] <= in_data;
			end else if (pop && i < DEPTH-1) begin
				mem_r[i] <= mem_r[(i+1) % DEPTH];
			end
		end
	end
endmodule : pair_buffer
`default_nettype wire

// File: tb/lin_far_node.sv
`timescale 1ns/1ps
`default_nettype none
module lin_far_node (
	input wire logic clk_sys,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	input wire logic stall,
	input wire logic corrupt,
	output logic hdr_done,
	output logic [7:0] hdr_pid,
	output logic rx_stb,
	output logic [7:0] rx_data,
	output logic stop_dominant,
	output logic break_seen,
	output logic sync_fault,
	output logic tx_ready,
	output logic tx_sent,
	output logic bit_sample,
	output logic tx_bit,
	output logic bus_rx
);
	logic [7:0] b;
	initial begin
		{hdr_done, rx_stb, stop_dominant, break_seen, sync_fault} = '0;
		{tx_ready, tx_sent, bit_sample} = '0;
		{hdr_pid, rx_data} = '0;
		{tx_bit, bus_rx} = 2'h3;
	end
	// -----------------------------
	// Header, byte and fault events
	// -----------------------------
	task automatic put(input int k, input logic [7:0] v);
		@(posedge clk_sys);
		hdr_pid <= v;
		rx_data <= v;
		hdr_done <= (k == 0);
		rx_stb <= (k == 1);
		stop_dominant <= (k == 2);
		break_seen <= (k == 3);
		sync_fault <= (k == 4);
		@(posedge clk_sys);
		{hdr_done, rx_stb, stop_dominant, break_seen, sync_fault} <= 5'h0;
		hdr_pid <= ~v;
		rx_data <= ~v;
		repeat (3) @(posedge clk_sys);
		@(negedge clk_sys);
	endtask : put
	// -----------------------------
	// Serialiser with stalls
	// -----------------------------
	initial begin
		forever begin
			@(posedge clk_sys);
			if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
				b = tx_data;
				tx_ready <= 1'b0;
				for (int i = 0; i < 8; i++) begin
					tx_bit <= b[i];
					bus_rx <= b[i] ^ corrupt;
					repeat (3) @(posedge clk_sys);
					bit_sample <= 1'b1;
					@(posedge clk_sys);
					bit_sample <= 1'b0;
				end
				tx_bit <= 1'b1;
				bus_rx <= 1'b1;
				tx_sent <= 1'b1;
				@(posedge clk_sys);
				tx_sent <= 1'b0;
			end else begin
				tx_ready <= !stall;
			end
		end
	end
endmodule : lin_far_node
`default_nettype wire

// File: tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb import lin_resp_pkg::*;;
	logic clk_sys, arst_n, lin_enable, legacy_protocol_select, cmd_wr, dl_wr;
	logic sel_wr, dat_wr, dat_rd, busy, stall, corrupt, increment_disable, tx_valid;
	logic [1:0] conf_sel;
	logic [2:0] cmd_wdata, command_field, ident_status_field, buffer_index;
	logic [7:0] dl_wdata, dat_wdata, hdr_pid, rx_data, tx_data, data_port, s, p;
	logic [3:0] flag_clr, interrupt_enable_register, sel_wdata;
	logic [3:0] rx_length_field, tx_length_field;
	logic hdr_done, rx_stb, tx_ready, tx_sent, bit_sample, tx_bit, bus_rx;
	logic stop_dominant, sync_fault, break_seen, irq_error, irq_event;
	logic rx_complete_flag, tx_complete_flag, header_done_flag, error_summary_flag;
	err_t error_register;
	logic [5:0] id;
	logic [31:0] rnd = 32'h5F52;
	logic [31:0] st = 32'h5F52;
	logic [7:0] exp_q[$];
	logic [7:0] d[3];
	int mismatches = 0;
	int comparisons = 0;
	lin_resp_ctrl #(.FRAME_CYC(200)) lin_resp_ctrl_i (.*);
	lin_far_node lin_far_node_i (.*);
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	function automatic logic [31:0] nxt(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : nxt
	function automatic logic [7:0] cadd(input logic [7:0] a, input logic [7:0] v);
		logic [8:0] t;
		t = a + v;
		return t[7:0] + t[8];
	endfunction : cadd
	function automatic logic [7:0] pid(input logic [5:0] v);
		return {~(v[1] ^ v[3] ^ v[4] ^ v[5]), v[0] ^ v[1] ^ v[2] ^ v[4], v};
	endfunction : pid
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic finish_test;
		if (mismatches == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : finish_test
	task automatic wr(input int k, input logic [7:0] v);
		@(posedge clk_sys);
		cmd_wdata <= v[2:0];
		dl_wdata <= v;
		sel_wdata <= v[3:0];
		dat_wdata <= v;
		cmd_wr <= (k == 0);
		dl_wr <= (k == 1);
		sel_wr <= (k == 2);
		dat_wr <= (k == 3);
		dat_rd <= (k == 4);
		flag_clr <= (k == 5) ? v[3:0] : 4'h0;
		@(posedge clk_sys);
		{cmd_wr, dl_wr, sel_wr, dat_wr, dat_rd} <= 5'h0;
		flag_clr <= 4'h0;
		@(negedge clk_sys);
	endtask : wr
	task automatic wait_idle;
		int n;
		n = 0;
		repeat (2) @(negedge clk_sys);
		while (busy !== 1'b0 && n < 3000) begin
			@(negedge clk_sys);
			n++;
		end
		if (n >= 3000) begin
			mismatches++;
			finish_test;
		end
	endtask : wait_idle
	always @(posedge clk_sys) begin
		st <= nxt(st);
		stall <= st[3] & st[5];
	end
	// ---------------------------
	// Handed-over byte scoreboard
	// ---------------------------
	always @(posedge clk_sys) begin
		if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
			chk(tx_data, (exp_q.size() > 0) ? exp_q.pop_front() : 32'h100);
		end
	end
	initial begin
		{arst_n, lin_enable, legacy_protocol_select, cmd_wr, dl_wr, sel_wr} = '0;
		{dat_wr, dat_rd, corrupt, cmd_wdata, dl_wdata, dat_wdata, flag_clr, sel_wdata} = '0;
		conf_sel = 2'h2;
		interrupt_enable_register = 4'hF;
		repeat (16) @(posedge clk_sys);
		arst_n <= 1'b1;
		@(negedge clk_sys);
		chk({command_field, busy, rx_length_field, tx_length_field}, 32'h0);
		chk({error_register, rx_complete_flag, tx_complete_flag, tx_valid}, 32'h0);
		@(posedge clk_sys) lin_enable <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			id = (i < 4) ? (6'h3C | 6'(i)) : 6'h15;
			lin_far_node_i.put(0, pid(id));
			chk({header_done_flag, irq_event, ident_status_field[2]}, {2'h3, i < 4});
			if (i < 4) chk(ident_status_field[1:0], id[1:0]);
			wr(5, 8'h04);
		end
		@(posedge clk_sys) legacy_protocol_select <= 1'b1;
		lin_far_node_i.put(0, pid(6'h25));
		chk({rx_length_field, tx_length_field}, 8'h44);
		lin_far_node_i.put(0, pid(6'h35));
		chk({rx_length_field, tx_length_field}, 8'h88);
		lin_far_node_i.put(0, pid(6'h0A));
		chk({rx_length_field, tx_length_field}, 8'h22);
		@(posedge clk_sys) legacy_protocol_select <= 1'b0;
		lin_far_node_i.put(0, pid(6'h15) ^ 8'h40);
		chk({error_register, error_summary_flag, irq_error}, 10'h013);
		wr(5, 8'h0C);
		chk({error_register, error_summary_flag, irq_error, header_done_flag}, 11'h0);
		p = pid(6'h15);
		lin_far_node_i.put(0, p);
		wr(1, 8'h03);
		wr(0, 8'h02);
		chk({command_field, busy, tx_length_field, rx_length_field}, 12'h503);
		s = p;
		for (int i = 0; i < 3; i++) begin
			rnd = nxt(rnd);
			d[i] = rnd[7:0];
			s = cadd(s, d[i]);
			lin_far_node_i.put(1, d[i]);
			chk({tx_length_field, rx_length_field}, {4'(i + 1), 4'h3});
		end
		lin_far_node_i.put(1, ~s);
		chk({rx_complete_flag, busy, tx_length_field, irq_event}, 7'h47);
		wr(5, 8'h0F);
		wr(2, 8'h00);
		@(negedge clk_sys);
		chk(data_port, d[0]);
		wr(4, 8'h00);
		@(negedge clk_sys);
		chk({buffer_index, data_port}, {3'h1, d[1]});
		wr(2, 8'h07);
		wr(4, 8'h00);
		chk(buffer_index, 3'h0);
		wr(2, 8'h0A);
		wr(4, 8'h00);
		chk({increment_disable, buffer_index}, 4'hA);
		for (int k = 1; k < 5; k++) begin
			lin_far_node_i.put(0, p);
			wr(1, 8'h01);
			wr(0, 8'h02);
			rnd = nxt(rnd);
			lin_far_node_i.put(1, rnd[7:0]);
			lin_far_node_i.put(k, ~cadd(p, rnd[7:0]) ^ 8'h01);
			chk({command_field, busy, tx_length_field, error_register}, {8'h01, (k == 1) ? 8'h02 : (k == 4) ? 8'h08 : 8'h10});
			wr(5, 8'h08);
		end
		lin_far_node_i.put(0, p);
		wr(2, 8'h00);
		s = 8'h00;
		for (int i = 0; i < 2; i++) begin
			rnd = nxt(rnd);
			d[i] = rnd[7:0];
			wr(3, d[i]);
			s = cadd(s, d[i]);
			exp_q.push_back(d[i]);
		end
		exp_q.push_back(~s);
		wr(1, 8'h20);
		@(posedge clk_sys) legacy_protocol_select <= 1'b1;
		wr(0, 8'h03);
		chk({busy, rx_length_field}, 5'h10);
		@(posedge clk_sys) legacy_protocol_select <= 1'b0;
		wait_idle;
		@(negedge clk_sys);
		chk({tx_complete_flag, rx_length_field, tx_length_field}, 9'h122);
		chk(exp_q.size(), 32'h0);
		wr(5, 8'h02);
		@(posedge clk_sys) corrupt <= 1'b1;
		exp_q.push_back(d[0]);
		wr(0, 8'h03);
		wait_idle;
		chk({command_field, rx_length_field, error_register}, 15'h0001);
		@(posedge clk_sys) corrupt <= 1'b0;
		wr(5, 8'h08);
		@(posedge clk_sys) conf_sel <= 2'h0;
		for (int k = 0; k < 2; k++) begin
			lin_far_node_i.put(0, p);
			wr(1, 8'h08);
			wr(0, 8'h02);
			repeat (250) @(negedge clk_sys);
			chk({busy, error_register}, (k == 1) ? 9'h100 : 9'h040);
			@(posedge clk_sys) conf_sel <= 2'(k + 1);
			wr(5, 8'h08);
		end
		wr(0, 8'h03);
		chk({busy, command_field, error_register}, 12'hA20);
		wr(0, 8'h00);
		chk({busy, command_field, error_register}, 12'h0A0);
		wr(0, 8'h01);
		chk({busy, command_field}, 4'h9);
		lin_far_node_i.put(0, p);
		chk({busy, header_done_flag}, 2'h1);
		wr(5, 8'h0F);
		wr(0, 8'h07);
		wr(1, 8'h55);
		chk({rx_length_field, tx_length_field}, 8'h00);
		for (int i = 0; i < 2; i++) begin
			rnd = nxt(rnd);
			lin_far_node_i.put(1, rnd[7:0]);
			chk({rx_complete_flag, data_port, error_register}, {1'b1, rnd[7:0], (i == 1) ? 8'h20 : 8'h00});
		end
		wr(4, 8'h00);
		chk(error_summary_flag, 1'b0);
		lin_far_node_i.put(0, p);
		chk(header_done_flag, 1'b0);
		rnd = nxt(rnd);
		exp_q.push_back(rnd[7:0]);
		wr(3, rnd[7:0]);
		wait_idle;
		@(negedge clk_sys);
		chk({tx_complete_flag, irq_event, exp_q.size() == 0}, 3'h7);
		@(posedge clk_sys) interrupt_enable_register <= 4'h0;
		repeat (2) @(negedge clk_sys);
		chk({tx_complete_flag, irq_event, irq_error}, 3'h4);
		finish_test;
	end
endmodule : tb
`default_nettype wire
